/* File: rtl/bxc_regs.sv */
// Purpose: extended configuration register bank, top level
// Assumes: one-cycle cfgWr or cfgRd strobes with dword address and byte enables
// Notes: read data valid two cycles after cfgRd, flagged by cfgRdValid
`timescale 1ns/1ps
module bxc_regs
   import bxc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cfgWr,
   input wire logic cfgRd,
   input wire logic [11:0] cfgAddr,
   input wire logic [3:0] cfgBe,
   input wire logic [31:0] cfgWdata,
   output logic [31:0] cfgRdata,
   output logic cfgRdValid,
   input wire logic logCapture,
   input wire logic [3:0] attrCbe,
   input wire logic [31:0] attrAd,
   input wire logic [3:0] addr1Cbe,
   input wire logic [31:0] addr1Ad,
   input wire logic [3:0] addr2Cbe,
   input wire logic [31:0] addr2Ad,
   input wire logic [3:0] spareInput,
   output logic [3:0] spareOutput,
   output logic [3:0] spareOutputDriveEnable,
   output logic [7:0] tcMap,
   output logic [11:0] replayTimer,
   output logic replayTimerEn,
   output logic [13:0] ackLatency
);
   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] beMask;
   logic [31:0] wd;
   logic [3:0] spareIn;
   logic [31:0] logData;
   logic [6:0] tcMap_r, tcMap_nxt;
   logic [3:0] spOut_r, spOut_nxt, spEn_r, spEn_nxt;
   logic [11:0] replay_r, replay_nxt;
   logic replayEn_r, replayEn_nxt;
   logic [13:0] ack_r, ack_nxt;
   logic rdPend_r, rdPend_nxt;
   logic rdLog_r, rdLog_nxt;
   logic [31:0] rdHold_r, rdHold_nxt;
   logic [31:0] rdOut_r, rdOut_nxt;
   logic rdValid_r, rdValid_nxt;
   logic [31:0] regVal;
   logic [1:0] logIdx;
   bxc_sync u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .din(spareInput),
      .dout(spareIn)
   );
   assign logIdx = 2'(cfgAddr[3:2] - OFS_LOG0[3:2]);
   bxc_log u_log (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .capture(logCapture),
      .attrCbe(attrCbe),
      .attrAd(attrAd),
      .addr1Cbe(addr1Cbe),
      .addr1Ad(addr1Ad),
      .addr2Cbe(addr2Cbe),
      .addr2Ad(addr2Ad),
      .rdIdx(logIdx),
      .rdData(logData)
   );
   ////////////////////////////////////////////////////////////////////////////
   // byte enables widened to a bit mask
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_be
         assign beMask[8*g+7:8*g] = {8{cfgBe[g]}};
      end
   endgenerate
   assign wd = cfgWdata & beMask;
   // write side: writable fields only, others ignored
   always_comb begin
      tcMap_nxt = tcMap_r;
      spOut_nxt = spOut_r;
      spEn_nxt = spEn_r;
      replay_nxt = replay_r;
      replayEn_nxt = replayEn_r;
      ack_nxt = ack_r;
      if (cfgWr && cfgAddr == OFS_RCTL && cfgBe[0]) begin
         tcMap_nxt = cfgWdata[7:TCMAP_LSB];
      end
      if (cfgWr && cfgAddr == OFS_SPARE) begin
         spOut_nxt = (spOut_r & ~wd[SP_CLR_LSB+:4]) | wd[SP_SET_LSB+:4];
         spEn_nxt = (spEn_r & ~wd[SP_ENCLR_LSB+:4]) | wd[SP_ENSET_LSB+:4];
      end
      if (cfgWr && cfgAddr == OFS_TIMER) begin
         if (cfgBe[0]) replay_nxt[7:0] = cfgWdata[7:0];
         if (cfgBe[1]) begin
            replay_nxt[11:8] = cfgWdata[11:8];
            replayEn_nxt = cfgWdata[TM_EN_POS];
         end
         if (cfgBe[2]) ack_nxt[7:0] = cfgWdata[23:16];
         if (cfgBe[3]) ack_nxt[13:8] = cfgWdata[29:24];
      end
   end
   // read mux for all non-log offsets
   always_comb begin
      regVal = 32'h00000000;
      unique case (cfgAddr)
         OFS_VCHDR: regVal = VCHDR_VAL;
         OFS_PCAP1: regVal = 32'h00000000;
         OFS_PCTLSTS: regVal = 32'h00000000;
         OFS_RCTL: regVal = {1'b1, 23'h000000, tcMap_r, 1'b1};
         OFS_SPARE: regVal = {12'h000, spareIn, spEn_r, spEn_r, spOut_r, spOut_r};
         OFS_TIMER: regVal = {2'h0, ack_r, 3'h0, replayEn_r, replay_r};
         default: regVal = 32'h00000000;
      endcase
   end
   // two-stage read pipe so the log memory can answer from its register
   always_comb begin
      rdPend_nxt = cfgRd;
      rdLog_nxt = cfgAddr >= OFS_LOG0 && cfgAddr <= OFS_LOG3;
      rdHold_nxt = regVal;
      rdValid_nxt = rdPend_r;
      rdOut_nxt = rdOut_r;
      if (rdPend_r) begin
         rdOut_nxt = rdLog_r ? logData : rdHold_r;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tcMap_r <= TCMAP_RST;
         spOut_r <= 4'h0;
         spEn_r <= 4'h0;
         replay_r <= REPLAY_RST;
         replayEn_r <= 1'b0;
         ack_r <= ACKLAT_RST;
         rdPend_r <= 1'b0;
         rdLog_r <= 1'b0;
         rdHold_r <= 32'h00000000;
         rdOut_r <= 32'h00000000;
         rdValid_r <= 1'b0;
      end else begin
         tcMap_r <= tcMap_nxt;
         spOut_r <= spOut_nxt;
         spEn_r <= spEn_nxt;
         replay_r <= replay_nxt;
         replayEn_r <= replayEn_nxt;
         ack_r <= ack_nxt;
         rdPend_r <= rdPend_nxt;
         rdLog_r <= rdLog_nxt;
         rdHold_r <= rdHold_nxt;
         rdOut_r <= rdOut_nxt;
         rdValid_r <= rdValid_nxt;
      end
   end
   assign cfgRdata = rdOut_r;
   assign cfgRdValid = rdValid_r;
   assign spareOutput = spOut_r;
   assign spareOutputDriveEnable = spEn_r;
   assign tcMap = {tcMap_r, 1'b1};
   assign replayTimer = replay_r;
   assign replayTimerEn = replayEn_r;
   assign ackLatency = ack_r;
   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   chk_spare_clear: assert property (
      cfgWr && cfgAddr == OFS_SPARE && cfgBe[0] && cfgWdata[0] && !cfgWdata[4]
      |=> !spareOutput[0]) else $error("spare output not cleared");
   chk_spare_set: assert property (
      cfgWr && cfgAddr == OFS_SPARE && cfgBe[0] && cfgWdata[4] |=> spareOutput[0])
      else $error("spare output not set");
   chk_enable_clear: assert property (
      cfgWr && cfgAddr == OFS_SPARE && cfgBe[1] && cfgWdata[8] && !cfgWdata[12]
      |=> !spareOutputDriveEnable[0]) else $error("drive enable not cleared");
   chk_enable_set: assert property (
      cfgWr && cfgAddr == OFS_SPARE && cfgBe[1] && cfgWdata[12]
      |=> spareOutputDriveEnable[0]) else $error("drive enable not set");
   chk_hdr_read: assert property (
      cfgRd && cfgAddr == OFS_VCHDR |=> ##1 cfgRdValid && cfgRdata == 32'h00010002)
      else $error("capability header wrong");
   chk_pctl_zero: assert property (
      cfgRd && cfgAddr == OFS_PCTLSTS |=> ##1 cfgRdata == 32'h00000000)
      else $error("port control not zero");
   chk_rctl_fixed: assert property (
      cfgRd && cfgAddr == OFS_RCTL |=> ##1 cfgRdata[31] && cfgRdata[0] && cfgRdata[30:8] == 0)
      else $error("resource control fixed bits wrong");
   chk_log_cmd: assert property (
      logCapture ##1 !logCapture ##1 (cfgRd && cfgAddr == OFS_LOG1 && !logCapture)
      |=> ##1 cfgRdata[7:4] == $past(addr1Cbe, 4)) else $error("log command wrong");
   chk_unmapped: assert property (
      cfgRd && cfgAddr == 12'h14c |=> ##1 cfgRdata == 32'h00000000)
      else $error("reserved offset not zero");
   chk_timer_rsvd: assert property (
      cfgRdValid |-> !(($past(cfgAddr, 2) == OFS_TIMER) && (cfgRdata[31:30] != 0)))
      else $error("timer reserved bits set");
   ////////////////////////////////////////////////////////////////////////////
   // attribute phase lines land in the low 36 log bits
   chk_log_attr: assert property (
      logCapture
      |=> {u_log.word_r[1][3:0], u_log.word_r[0]} == $past({attrCbe, attrAd}))
      else $error("log attribute phase not captured");
   // first address phase command lands in bits 39:36
   chk_log_lower: assert property (
      logCapture
      |=> u_log.word_r[1][7:4] == $past(addr1Cbe))
      else $error("log lower command not captured");
   // second address phase command in bits 43:40, bits 63:44 stay zero
   chk_log_upper: assert property (
      logCapture
      |=> u_log.word_r[1][31:8] == {20'h00000, $past(addr2Cbe)})
      else $error("log upper command not captured");
   // first address phase data in the third dword
   chk_log_addr1: assert property (
      logCapture
      |=> u_log.word_r[2] == $past(addr1Ad))
      else $error("log first address not captured");
   // second address phase data in the fourth dword
   chk_log_addr2: assert property (
      logCapture
      |=> u_log.word_r[3] == $past(addr2Ad))
      else $error("log second address not captured");
   // without a capture the whole log holds
   chk_log_sticky: assert property (
      !logCapture
      |=> $stable(u_log.word_r[0]) && $stable(u_log.word_r[1])
         && $stable(u_log.word_r[2]) && $stable(u_log.word_r[3]))
      else $error("log changed without capture");
   // port channel capability one reads zero
   chk_pcap1_zero: assert property (
      cfgRd && cfgAddr == OFS_PCAP1
      |=> ##1 cfgRdata == 32'h00000000)
      else $error("port capability one not zero");
   // remaining capability and status dwords read zero
   chk_cap_zero: assert property (
      cfgRd && (cfgAddr == OFS_PCAP2 || cfgAddr == OFS_RCAP || cfgAddr == OFS_RSTS)
      |=> ##1 cfgRdata == 32'h00000000)
      else $error("capability or status not zero");
   // reserved ranges around the spare and timer dwords read zero
   chk_rsvd_range: assert property (
      cfgRd && ((cfgAddr > OFS_RSTS && cfgAddr < OFS_SPARE)
         || (cfgAddr > OFS_SPARE && cfgAddr != OFS_TIMER))
      |=> ##1 cfgRdata == 32'h00000000)
      else $error("reserved range not zero");
   // every read is answered exactly two cycles after its strobe
   chk_valid_timing: assert property (
      cfgRdValid == $past(cfgRd, 2))
      else $error("read valid not two cycles after request");
   // map bits 7:1 follow a write with byte 0 enabled
   chk_tc_write: assert property (
      cfgWr && cfgAddr == OFS_RCTL && cfgBe[0]
      |=> tcMap == {$past(cfgWdata[7:1]), 1'b1})
      else $error("channel map write lost");
   // map holds when not written
   chk_tc_hold: assert property (
      !(cfgWr && cfgAddr == OFS_RCTL && cfgBe[0])
      |=> $stable(tcMap))
      else $error("channel map changed without write");
   // map read returns the stored map
   chk_rctl_map: assert property (
      cfgRd && cfgAddr == OFS_RCTL
      |=> ##1 cfgRdata[7:0] == $past(tcMap, 2))
      else $error("channel map read wrong");
   // zeros in both clear and set bits leave an output alone
   chk_out_keep: assert property (
      cfgWr && cfgAddr == OFS_SPARE && cfgBe[0] && !cfgWdata[1] && !cfgWdata[5]
      |=> spareOutput[1] == $past(spareOutput[1]))
      else $error("spare output moved on zero write");
   // zeros in both clear and set bits leave an enable alone
   chk_enable_keep: assert property (
      cfgWr && cfgAddr == OFS_SPARE && cfgBe[1] && !cfgWdata[9] && !cfgWdata[13]
      |=> spareOutputDriveEnable[1] == $past(spareOutputDriveEnable[1]))
      else $error("drive enable moved on zero write");
   // outputs and enables hold when the spare dword is not written
   chk_spare_hold: assert property (
      !(cfgWr && cfgAddr == OFS_SPARE)
      |=> $stable(spareOutput) && $stable(spareOutputDriveEnable))
      else $error("spare pins changed without write");
   // spare read shows synced pins, zero upper bits and the outputs
   chk_spare_read: assert property (
      cfgRd && cfgAddr == OFS_SPARE
      |=> ##1 cfgRdata[31:16] == {12'h000, $past(spareIn, 2)}
         && cfgRdata[3:0] == $past(spareOutput, 2))
      else $error("spare register read wrong");
   // full timer write loads all writable fields
   chk_timer_write: assert property (
      cfgWr && cfgAddr == OFS_TIMER && cfgBe == 4'hf
      |=> {ackLatency, replayTimerEn, replayTimer} == $past({cfgWdata[29:16], cfgWdata[12:0]}))
      else $error("timer write lost");
   // disabled bytes 1 and 3 of a timer write are kept
   chk_timer_part: assert property (
      cfgWr && cfgAddr == OFS_TIMER && !cfgBe[1] && !cfgBe[3]
      |=> $stable({ackLatency[13:8], replayTimerEn, replayTimer[11:8]}))
      else $error("timer byte enables ignored");
   // timer read returns the stored fields
   chk_timer_read: assert property (
      cfgRd && cfgAddr == OFS_TIMER
      |=> ##1 cfgRdata[29:0] == $past({ackLatency, 3'h0, replayTimerEn, replayTimer}, 2))
      else $error("timer read wrong");
   // main scenarios seen
   cov_spare_wr: cover property (cfgWr && cfgAddr == OFS_SPARE);
   cov_log_rd: cover property (cfgRd && cfgAddr == OFS_LOG3);
   cov_tc_wr: cover property (cfgWr && cfgAddr == OFS_RCTL);
   cov_log_cap: cover property (logCapture);
   cov_timer_wr: cover property (cfgWr && cfgAddr == OFS_TIMER);
endmodule // bxc_regs

/* File: rtl/bxc_pkg.sv */
// Purpose: constants for the bridge extended configuration register bank
// Assumes: dword configuration accesses with byte enables, one clock ref_clk
// Notes: offsets are byte addresses of aligned dwords
// Operation
// - log bits 35:0 keep byte enables and data of the attribute phase, reset zero
// - log bits 39:36 keep byte enables of the first address phase
// - log bits 43:40 keep second address phase byte enables; 63:44 read zero
// - log bits 95:64 keep data lines of the first address phase
// - log bits 127:96 keep second address phase data; log spans four dwords
// - capability header reads identifier 0002h, version 1h, next pointer zero
// - port channel control and status read zero; writes ignored
// - class 0 map bit reads 1, bits 7:1 writable reset 7Fh, bit 31 reads 1
// - writing 1 to bits 3:0 clears the matching spare output
// - writing 1 to bits 7:4 sets the matching spare output
// - writing 1 to bits 11:8 clears the matching drive enable; reset zero
// - writing 1 to bits 15:12 sets the matching drive enable
// - bits 19:16 return spare input levels; bits 31:20 read zero
// - timer register: 12-bit replay, enable bit 12, 14-bit ack latency, bit 30 zero
package bxc_pkg;
   localparam logic [11:0] OFS_LOG0 = 12'h13c;
   localparam logic [11:0] OFS_LOG1 = 12'h140;
   localparam logic [11:0] OFS_LOG2 = 12'h144;
   localparam logic [11:0] OFS_LOG3 = 12'h148;
   localparam logic [11:0] OFS_VCHDR = 12'h150;
   localparam logic [11:0] OFS_PCAP1 = 12'h154;
   localparam logic [11:0] OFS_PCAP2 = 12'h158;
   localparam logic [11:0] OFS_PCTLSTS = 12'h15c;
   localparam logic [11:0] OFS_RCAP = 12'h160;
   localparam logic [11:0] OFS_RCTL = 12'h164;
   localparam logic [11:0] OFS_RSTS = 12'h168;
   localparam logic [11:0] OFS_SPARE = 12'h304;
   localparam logic [11:0] OFS_TIMER = 12'h310;
   localparam logic [31:0] VCHDR_VAL = 32'h00010002;
   localparam logic [6:0] TCMAP_RST = 7'h7f;
   localparam int TCMAP_LSB = 1;
   localparam int VCEN_POS = 31;
   localparam int SP_CLR_LSB = 0;
   localparam int SP_SET_LSB = 4;
   localparam int SP_ENCLR_LSB = 8;
   localparam int SP_ENSET_LSB = 12;
   localparam int SP_IN_LSB = 16;
   localparam int TM_ACK_LSB = 16;
   localparam int TM_EN_POS = 12;
   localparam logic [11:0] REPLAY_RST = 12'h000;
   localparam logic [13:0] ACKLAT_RST = 14'h0000;
endpackage

/* File: rtl/bxc_sync.sv */
// Purpose: two-stage synchroniser for the spare input pins
// Assumes: pins are asynchronous to ref_clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module bxc_sync
   import bxc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [3:0] din,
   output logic [3:0] dout
);
   logic [3:0] meta_r;
   logic [3:0] meta_nxt;
   logic [3:0] dout_nxt;
   // next values are plain shift
   always_comb begin
      meta_nxt = din;
      dout_nxt = meta_r;
   end
   // two flip-flops per pin
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= 4'h0;
         dout <= 4'h0;
      end else begin
         meta_r <= meta_nxt;
         dout <= dout_nxt;
      end
   end
endmodule // bxc_sync

/* File: rtl/bxc_log.sv */
// Purpose: sticky secondary transaction header log
// Assumes: capture strobe and phase values come from the secondary bus logic
// Notes: read data leave a register
`timescale 1ns/1ps
module bxc_log
   import bxc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic capture,
   input wire logic [3:0] attrCbe,
   input wire logic [31:0] attrAd,
   input wire logic [3:0] addr1Cbe,
   input wire logic [31:0] addr1Ad,
   input wire logic [3:0] addr2Cbe,
   input wire logic [31:0] addr2Ad,
   input wire logic [1:0] rdIdx,
   output logic [31:0] rdData
);
   logic [31:0] word_r [4];
   logic [31:0] word_nxt [4];
   logic [31:0] rdData_nxt;
   // capture all four dwords at once on the trigger
   always_comb begin
      word_nxt = word_r;
      if (capture) begin
         word_nxt[0] = attrAd;
         word_nxt[1] = {20'h00000, addr2Cbe, addr1Cbe, attrCbe};
         word_nxt[2] = addr1Ad;
         word_nxt[3] = addr2Ad;
      end
      rdData_nxt = word_r[rdIdx];
   end
   // storage and registered read port
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            word_r[i] <= 32'h00000000;
         end
         rdData <= 32'h00000000;
      end else begin
         word_r <= word_nxt;
         rdData <= rdData_nxt;
      end
   end
endmodule // bxc_log

/* File: tb/tb_bridge_ext_config_registers.sv */
// Purpose: self-checking bench for the extended configuration register bank
// Assumes: one-cycle cfgWr/cfgRd strobes, read data flagged two cycles later
// Notes: inputs change on the falling edge, results are sampled there too
`timescale 1ns/1ps
module tb_bridge_ext_config_registers;
   import bxc_pkg::*;
   logic ref_clk, nrst, cfgWr, cfgRd, cfgRdValid, logCapture, replayTimerEn;
   logic [11:0] cfgAddr, replayTimer;
   logic [3:0] cfgBe, attrCbe, addr1Cbe, addr2Cbe, spareInput, spareOutput;
   logic [3:0] spareOutputDriveEnable;
   logic [31:0] cfgWdata, cfgRdata, attrAd, addr1Ad, addr2Ad;
   logic [7:0] tcMap;
   logic [13:0] ackLatency;
   int errTotal = 0;
   int checked = 0;
   // read-only and unmapped places with their expected contents
   logic [11:0] roAddr [13] = '{12'h13c, 12'h140, 12'h144, 12'h148, 12'h14c, 12'h150,
      12'h154, 12'h158, 12'h15c, 12'h160, 12'h168, 12'h308, 12'h314};
   logic [31:0] roExp [13] = '{0, 0, 0, 0, 0, 32'h00010002, 0, 0, 0, 0, 0, 0, 0};

   bxc_regs uut (.ref_clk(ref_clk), .nrst(nrst), .cfgWr(cfgWr), .cfgRd(cfgRd),
      .cfgAddr(cfgAddr), .cfgBe(cfgBe), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
      .cfgRdValid(cfgRdValid), .logCapture(logCapture), .attrCbe(attrCbe),
      .attrAd(attrAd), .addr1Cbe(addr1Cbe), .addr1Ad(addr1Ad), .addr2Cbe(addr2Cbe),
      .addr2Ad(addr2Ad), .spareInput(spareInput), .spareOutput(spareOutput),
      .spareOutputDriveEnable(spareOutputDriveEnable), .tcMap(tcMap),
      .replayTimer(replayTimer), .replayTimerEn(replayTimerEn), .ackLatency(ackLatency));

   ////////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare, report and close
   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      checked++;
      if (seen !== expd) begin
         errTotal++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask

   task automatic endOfTest();
      $display("comparisons %0d, mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // reset held for six cycles, released off the sampling edge
   task automatic doReset();
      nrst = 1'b0;
      repeat (6) @(negedge ref_clk);
      nrst = 1'b1;
   endtask

   task automatic cfgWrite(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge ref_clk);
      cfgWr = 1'b1;
      cfgAddr = a;
      cfgBe = be;
      cfgWdata = d;
      @(negedge ref_clk);
      cfgWr = 1'b0;
   endtask

   // read one dword, bounded wait for the valid pulse, then compare
   task automatic rdChk(input logic [11:0] a, input logic [31:0] expd);
      int n;
      n = 0;
      @(negedge ref_clk);
      cfgRd = 1'b1;
      cfgAddr = a;
      @(negedge ref_clk);
      cfgRd = 1'b0;
      while (cfgRdValid !== 1'b1 && n < 4) begin
         @(negedge ref_clk);
         n++;
      end
      if (cfgRdValid !== 1'b1) begin
         errTotal++;
         endOfTest();
      end else begin
         check(cfgRdata, expd);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {nrst, cfgWr, cfgRd, logCapture, cfgAddr, cfgBe, cfgWdata} = '0;
      {attrCbe, attrAd, addr1Cbe, addr1Ad, addr2Cbe, addr2Ad} = '0;
      spareInput = 4'ha;
      doReset();
      check({24'h0, tcMap}, 32'hff);
      check({24'h0, spareOutputDriveEnable, spareOutput}, 32'h0);
      check({replayTimerEn, ackLatency, replayTimer}, 32'h0);
      // second pass follows an all-ones write to every place
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 13; i++) begin
            rdChk(roAddr[i], roExp[i]);
            if (p == 0) cfgWrite(roAddr[i], 4'hf, 32'hffffffff);
         end
      end
      rdChk(OFS_RCTL, 32'h800000ff);
      rdChk(OFS_SPARE, 32'h000a0000);
      rdChk(OFS_TIMER, 32'h0);
      // channel map: only bits 7:1 move
      cfgWrite(OFS_RCTL, 4'hf, 32'h7fffff00);
      rdChk(OFS_RCTL, 32'h80000001);
      check({24'h0, tcMap}, 32'h01);
      cfgWrite(OFS_RCTL, 4'hf, 32'h000000aa);
      cfgWrite(OFS_RCTL, 4'he, 32'h000000fe);
      rdChk(OFS_RCTL, 32'h800000ab);
      // spare pins: set all, then clear some, then clear and set together
      cfgWrite(OFS_SPARE, 4'hf, 32'h0000f0f0);
      rdChk(OFS_SPARE, 32'h000affff);
      cfgWrite(OFS_SPARE, 4'hf, 32'hfff00501);
      rdChk(OFS_SPARE, 32'h000aaaee);
      check({24'h0, spareOutputDriveEnable, spareOutput}, 32'hae);
      cfgWrite(OFS_SPARE, 4'hf, 32'h00000019);
      cfgWrite(OFS_SPARE, 4'hd, 32'h0000ff00);
      spareInput = 4'h5;
      repeat (4) @(negedge ref_clk);
      rdChk(OFS_SPARE, 32'h0005aa77);
      check({24'h0, spareOutputDriveEnable, spareOutput}, 32'ha7);
      // timers
      cfgWrite(OFS_TIMER, 4'hf, 32'hffffffff);
      rdChk(OFS_TIMER, 32'h3fff1fff);
      check({replayTimerEn, ackLatency, replayTimer}, 32'h7ffffff);
      cfgWrite(OFS_TIMER, 4'hf, 32'h12345678);
      rdChk(OFS_TIMER, 32'h12341678);
      cfgWrite(OFS_TIMER, 4'h5, 32'hffffffff);
      rdChk(OFS_TIMER, 32'h12ff16ff);
      // header log capture, then new phase values without capture
      @(negedge ref_clk);
      {attrCbe, attrAd, addr1Cbe, addr1Ad} = {4'h3, 32'h11223344, 4'h7, 32'h89abcdef};
      {addr2Cbe, addr2Ad} = {4'hd, 32'h01234567};
      logCapture = 1'b1;
      @(negedge ref_clk);
      logCapture = 1'b0;
      {attrCbe, attrAd, addr1Cbe, addr1Ad, addr2Cbe, addr2Ad} = '1;
      // command dword first, two cycles after the capture
      rdChk(OFS_LOG1, 32'h00000d73);
      rdChk(OFS_LOG0, 32'h11223344);
      rdChk(OFS_LOG2, 32'h89abcdef);
      rdChk(OFS_LOG3, 32'h01234567);
      // reset in mid-run clears log and restores map to FFh
      doReset();
      rdChk(OFS_LOG3, 32'h0);
      rdChk(OFS_LOG1, 32'h0);
      check({24'h0, tcMap}, 32'hff);
      endOfTest();
   end
endmodule // tb_bridge_ext_config_registers
